// file: src/d2pc_map.svh
// Register map constants for the die 2 power control block.
// Included by the package-using design file and by the checker; definitions only.
`ifndef D2PC_MAP_SVH
`define D2PC_MAP_SVH

// Printed offset 0xd5 is not a multiple of four: it is the word index
`define D2PC_CTRL_IDX        8'hd5
// Upper-bank select register, index of our own choosing
`define D2PC_BANK_IDX        8'hd4
// Status register showing the effective controls, index of our own choosing
`define D2PC_STAT_IDX        8'hd6
`define D2PC_CTRL_RESET      16'h0000
`define D2PC_BANK_RESET      1'b0
`define D2PC_FULL_POS        15
`define D2PC_QUICK_POS       14
`define D2PC_PREAMP_POS      13
`define D2PC_ATTAMP_POS      12
`define D2PC_PROF_HI         11
`define D2PC_PROF_LO         10
`define D2PC_LNF_POS         9
`define D2PC_ZERO_POS        8
`define D2PC_CHAN_HI         7
// Bits that software may write; bit 8 is held at zero
`define D2PC_CTRL_WMASK      16'hfeff

`endif

// file: src/d2pc_pkg.sv
// Types for the die 2 power control block.
// Shared by the design file and the bench.
package d2pc_pkg;
    typedef enum logic [1:0] {
        D2PC_PROF_LOW_NOISE  = 2'h0,
        D2PC_PROF_LOW_POWER  = 2'h1,
        D2PC_PROF_MED_POWER  = 2'h2,
        D2PC_PROF_RESERVED   = 2'h3
    } d2pc_profile_t;

    typedef enum logic [2:0] {
        D2PC_ST_IDLE  = 3'h1,
        D2PC_ST_WRITE = 3'h2,
        D2PC_ST_READ  = 3'h4
    } d2pc_state_t;
endpackage : d2pc_pkg

// file: src/d2pc_ctrl.sv
// Die 2 power control register with an AHB-Lite slave port.
// Assumes one AHB-Lite master, single word transfers, hclk at 25 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "d2pc_map.svh"

module d2pc_ctrl
    import d2pc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             die2_full_powerdown,
    output logic             die2_quick_powerdown,
    output logic             die2_preamp_off,
    output logic             die2_atten_amp_off,
    output logic      [1:0]  die2_power_profile,
    output logic             die2_low_noise_figure,
    output logic      [7:0]  chan_off,
    output logic             adc_powerdown
);

    logic [15:0]   ctrl_r;
    logic          bank_r;
    d2pc_state_t   state_r;
    logic [7:0]    idx_r;
    logic [15:0]   ctrl_nxt;
    logic          wr_ctrl;
    logic          wr_bank;
    logic [15:0]   ctrl_fwd;
    logic          bank_fwd;

    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction : word_index

    // Every die 2 control acts only while the upper bank is selected
    function automatic logic bank_gate(input logic sel, input logic bit_v);
        bank_gate = sel & bit_v;
    endfunction : bank_gate

    // Only whole-word NONSEQ or SEQ transfers are taken; others are answered OKAY and ignored
    wire take = hsel && hready && htrans[1] && (hsize == 3'h2) && (haddr[1:0] == 2'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= D2PC_ST_IDLE;
            idx_r   <= 8'h00;
        end else if (take) begin
            state_r <= hwrite ? D2PC_ST_WRITE : D2PC_ST_READ;
            idx_r   <= word_index(haddr);
        end else begin
            state_r <= D2PC_ST_IDLE;
        end
    end

    // Bit 8 is masked so it always reads back zero
    always_comb begin
        ctrl_nxt = hwdata[15:0] & `D2PC_CTRL_WMASK;
    end

    // Write strobes of the data phase
    always_comb begin
        wr_ctrl = (state_r == D2PC_ST_WRITE) && (idx_r == `D2PC_CTRL_IDX);
        wr_bank = (state_r == D2PC_ST_WRITE) && (idx_r == `D2PC_BANK_IDX);
    end

    // A control or bank read whose address phase meets the data phase of a write to it sees the new value,
    // so a back-to-back write then read of either never returns stale data
    always_comb begin
        ctrl_fwd = wr_ctrl ? ctrl_nxt : ctrl_r;
        bank_fwd = wr_bank ? hwdata[0] : bank_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `D2PC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_r <= `D2PC_BANK_RESET;
        end else if (wr_bank) begin
            bank_r <= hwdata[0];
        end
    end

    // Read data is registered in the address phase and stands during the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (word_index(haddr))
                `D2PC_CTRL_IDX: hrdata <= {16'h0000, ctrl_fwd};
                `D2PC_BANK_IDX: hrdata <= {31'h0000_0000, bank_fwd};
                `D2PC_STAT_IDX: hrdata <= {16'h0000, die2_full_powerdown,
                    die2_quick_powerdown, die2_preamp_off, die2_atten_amp_off,
                    die2_power_profile, die2_low_noise_figure, 1'b0, chan_off};
                default:        hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states: the data phase always completes in one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Effective controls, gated by the upper-bank select; each lags its register by one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die2_full_powerdown <= 1'b0;
        end else begin
            die2_full_powerdown <= bank_gate(bank_r, ctrl_r[`D2PC_FULL_POS]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die2_quick_powerdown <= 1'b0;
        end else begin
            die2_quick_powerdown <= bank_gate(bank_r, ctrl_r[`D2PC_QUICK_POS]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die2_preamp_off <= 1'b0;
        end else begin
            die2_preamp_off <= bank_gate(bank_r, ctrl_r[`D2PC_PREAMP_POS]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die2_atten_amp_off <= 1'b0;
        end else begin
            die2_atten_amp_off <= bank_gate(bank_r, ctrl_r[`D2PC_ATTAMP_POS]);
        end
    end

    // Profile passes only when the bank is selected, else low noise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die2_power_profile <= D2PC_PROF_LOW_NOISE;
        end else begin
            die2_power_profile <= bank_r ? ctrl_r[`D2PC_PROF_HI:`D2PC_PROF_LO]
                                         : D2PC_PROF_LOW_NOISE;
        end
    end

    // Low noise figure is honoured only with the low-noise profile, so a
    // wrong write order by software cannot enable it in another profile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die2_low_noise_figure <= 1'b0;
        end else begin
            die2_low_noise_figure <= bank_gate(bank_r, ctrl_r[`D2PC_LNF_POS]
                & (ctrl_r[`D2PC_PROF_HI:`D2PC_PROF_LO] == D2PC_PROF_LOW_NOISE));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_off <= 8'h00;
        end else begin
            chan_off <= {8{bank_r}} & ctrl_r[`D2PC_CHAN_HI:0];
        end
    end

    // Converter power is never touched by this register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_powerdown <= 1'b0;
        end else begin
            adc_powerdown <= 1'b0;
        end
    end

endmodule : d2pc_ctrl
`default_nettype wire

// file: verif/d2pc_ctrl_checker.sv
// Assertions for the die 2 power control block.
// Bound to d2pc_ctrl; mirrors bank and control from the bus only.
`timescale 1ns/1ps
`default_nettype none
`include "d2pc_map.svh"
module d2pc_ctrl_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic [1:0]  htrans,
    input wire logic [1:0]  die2_power_profile,
    input wire logic [2:0]  hsize,
    input wire logic [7:0]  chan_off,
    input wire logic        die2_full_powerdown,
    input wire logic        die2_quick_powerdown,
    input wire logic        die2_preamp_off,
    input wire logic        die2_atten_amp_off,
    input wire logic        die2_low_noise_figure,
    input wire logic        adc_powerdown
);
    logic        go, wr, bk;
    logic [7:0]  idx;
    logic [15:0] cm;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {go, wr, bk, idx, cm} <= '0;
        end else if (hready) begin
            go <= hsel & htrans[1] & (hsize == 3'h2) & (haddr[1:0] == 2'h0);
            wr <= hwrite;
            idx <= haddr[9:2];
            if (go & wr & (idx == `D2PC_BANK_IDX)) bk <= hwdata[0];
            if (go & wr & (idx == `D2PC_CTRL_IDX)) cm <= hwdata[15:0] & `D2PC_CTRL_WMASK;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_s;
        go & !wr & (idx == `D2PC_CTRL_IDX) & hready;
    endsequence
    full_pd_a: assert property (die2_full_powerdown == $past(bk & cm[15]))
        else $error("full power-down wrong");
    quick_pd_a: assert property (die2_quick_powerdown == $past(bk & cm[14]))
        else $error("quick power-down wrong");
    preamp_pd_a: assert property (die2_preamp_off == $past(bk & cm[13]))
        else $error("preamp off wrong");
    atten_pd_a: assert property (die2_atten_amp_off == $past(bk & cm[12]))
        else $error("atten amp off wrong");
    prof_sel_a: assert property (die2_power_profile == $past(bk ? cm[11:10] : 2'h0))
        else $error("profile wrong");
    low_nf_a: assert property (die2_low_noise_figure == $past(bk & cm[9] & !(|cm[11:10])))
        else $error("low noise figure wrong");
    chan_pd_a: assert property (chan_off == $past({8{bk}} & cm[7:0]))
        else $error("channel off wrong");
    conv_on_a: assert property (!adc_powerdown)
        else $error("converter powered down");
    read_back_a: assert property (rd_s |-> hrdata == {16'h0, cm})
        else $error("read back wrong");
endmodule : d2pc_ctrl_checker
bind d2pc_ctrl d2pc_ctrl_checker i_chk (.*);
`default_nettype wire

// file: verif/d2pc_ctrl_tb.sv
// Bench for the die 2 power control block.
// Drives the AHB-Lite port itself; hready is looped from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module d2pc_ctrl_tb;
    import d2pc_pkg::*;
    localparam logic [31:0] ctrl_a = 32'h354, bank_a = 32'h350, stat_a = 32'h358;
    logic [2:0]  hsize = 3'h2;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy, hresp, fp, qp, po, ao, lnf, adc;
    logic [1:0]  htrans = 0, prof;
    logic [7:0]  chan;
    logic [15:0] c;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    int          errors = 0, tests_run = 0, cyc = 0;
    wire  [15:0] outs = {fp, qp, po, ao, prof, lnf, 1'b0, chan};
    always #20 hclk = ~hclk;
    d2pc_ctrl i_d2pc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .die2_full_powerdown(fp),
        .die2_quick_powerdown(qp), .die2_preamp_off(po), .die2_atten_amp_off(ao),
        .die2_power_profile(prof), .die2_low_noise_figure(lnf), .chan_off(chan),
        .adc_powerdown(adc));
    task automatic check(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // Address phase held until hready, then data phase until hready again
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        do @(posedge hclk); while (hrdy !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hrdy !== 1'b1);
        rd = hrdata;
        check("okay", {31'h0, hresp}, 0);
    endtask : bus
    // Outputs follow one edge after the register edge
    task automatic outs_chk(input string n, input logic [15:0] e);
        repeat (2) @(posedge hclk);
        check(n, {16'h0, outs}, {16'h0, e});
    endtask : outs_chk
    function automatic logic [15:0] exp_o(input logic [15:0] v);
        return {v[15:10], v[9] & (v[11:10] == 2'h0), 1'b0, v[7:0]};
    endfunction : exp_o
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, ctrl_a, 0);
        check("ctrl reset", rd, 0);
        bus(1, ctrl_a, 32'hffff);
        outs_chk("bank off", 0);
        bus(0, ctrl_a, 0);
        check("bit8 zero", rd, 32'hfeff);
        hsize <= 3'h0;
        bus(1, ctrl_a, 0);
        hsize <= 3'h2;
        bus(0, ctrl_a, 0);
        check("byte write dropped", rd, 32'hfeff);
        bus(1, bank_a, 1);
        outs_chk("all on", exp_o(16'hffff));
        check("converter", {31'h0, adc}, 0);
        for (int i = 0; i < 8; i++) begin
            c = {i[0], !i[0], i[1], !i[1], i[1:0], 2'h2, 8'h01 << i};
            bus(1, ctrl_a, {16'h0, c & 16'hfdff});
            bus(1, ctrl_a, {16'h0, c});
            outs_chk("fields", exp_o(c));
            bus(0, ctrl_a, 0);
            check("read", rd, {16'h0, c});
            bus(0, stat_a, 0);
            check("status", rd, {16'h0, exp_o(c)});
        end
        bus(0, 32'h360, 0);
        check("unmapped", rd, 0);
        bus(1, bank_a, 0);
        outs_chk("bank cleared", 0);
        bus(1, bank_a, 1);
        outs_chk("bank set", exp_o(c));
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check("reset outs", {16'h0, outs}, 0);
        hresetn <= 1'b1;
        bus(0, ctrl_a, 0);
        check("ctrl after reset", rd, 0);
        bus(0, bank_a, 0);
        check("bank after reset", rd, 0);
        wrap_up;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 2000) begin
            errors++;
            wrap_up;
        end
    end
endmodule : d2pc_ctrl_tb
`default_nettype wire
